/* external_reset_pin_control.v */
// How it works
// - Whole device held in reset while hard reset pin is low.
// - Hard reset release runs power-on reset of all but clock domain, then execution.
// - Device stays in software reset while soft pin is sensed low.
// - Soft reset covers core, digital registers and peripherals on core supply.
// - Soft reset spares power-on-only registers, clock logic, debug engine and debugger.
// - After sensing soft pin low, device drives it low as output.
// - Drive lasts exactly six system clock cycles, then pin is released.
// - Alternate sensing and driving until pin sensed high, then end reset.
`timescale 1ns/1ps
`default_nettype none
`include "reset_pin_regs.vh"
module external_reset_pin_control #(
    parameter SOFT_DRIVE_CYCLES = `SOFT_DRIVE_CYCLES,
    parameter POR_SEQ_CYCLES    = `POR_SEQ_CYCLES
) (
    input  wire sys_clk_in,
    input  wire reset_in,
    input  wire hard_reset_in_n,
    input  wire soft_reset_in_n,
    output wire soft_reset_out,
    output wire soft_reset_oe_out,
    output reg  por_reset_out,
    output reg  core_reset_out,
    output reg  cpu_run_out
);
    // Synchronised pin levels
    wire                          hard_sync;
    wire                          soft_sync;

    // State codes, binary
    localparam [1:0]              ST_POR   = `ST_POR;
    localparam [1:0]              ST_RUN   = `ST_RUN;
    localparam [1:0]              ST_DRIVE = `ST_DRIVE;
    localparam [1:0]              ST_SENSE = `ST_SENSE;

    // Terminal counts, cut to counter width on purpose
    localparam integer            POR_LAST_I   = POR_SEQ_CYCLES - 1;
    localparam integer            DRIVE_LAST_I = SOFT_DRIVE_CYCLES - 1;
    localparam integer            SENSE_LAST_I = `SENSE_CYCLES - 1;
    localparam [`POR_CNT_W-1:0]   POR_LAST     = POR_LAST_I[`POR_CNT_W-1:0];
    localparam [`SOFT_CNT_W-1:0]  DRIVE_LAST   = DRIVE_LAST_I[`SOFT_CNT_W-1:0];
    localparam [`SENSE_CNT_W-1:0] SENSE_LAST   = SENSE_LAST_I[`SENSE_CNT_W-1:0];

    // Sequencer state and counters
    reg  [1:0]                    state_q;
    reg  [1:0]                    state_d;
    reg  [`POR_CNT_W-1:0]         por_cnt_q;
    reg  [`POR_CNT_W-1:0]         por_cnt_d;
    reg  [`SOFT_CNT_W-1:0]        drive_cnt_q;
    reg  [`SOFT_CNT_W-1:0]        drive_cnt_d;
    reg  [`SENSE_CNT_W-1:0]       sense_cnt_q;
    reg  [`SENSE_CNT_W-1:0]       sense_cnt_d;

    // Next values of the reset outputs
    reg                           por_reset_d;
    reg                           core_reset_d;
    reg                           cpu_run_d;

    // Terminal count flags
    wire                          por_done;
    wire                          drive_done;
    wire                          sense_done;

    // Pins cross into the clock domain; hard pin idles in reset until seen high
    pin_sync #(.RESET_VAL(1'b0)) u_hard_sync (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .pin_in     (hard_reset_in_n),
        .pin_out    (hard_sync)
    );
    pin_sync #(.RESET_VAL(1'b1)) u_soft_sync (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .pin_in     (soft_reset_in_n),
        .pin_out    (soft_sync)
    );

    // Terminal count decode
    assign por_done   = (por_cnt_q == POR_LAST);
    assign drive_done = (drive_cnt_q == DRIVE_LAST);
    assign sense_done = (sense_cnt_q == SENSE_LAST);

    // Open drain: only ever drive a zero, enable only while driving
    assign soft_reset_out    = 1'b0;
    assign soft_reset_oe_out = (state_q == ST_DRIVE);

    // Next state; a low hard pin overrides every other condition
    always @* begin
        state_d = state_q;
        if (!hard_sync) begin
            state_d = ST_POR;
        end else begin
            case (state_q)
                ST_POR: begin
                    if (por_done) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!soft_sync) begin
                        state_d = ST_DRIVE;
                    end
                end
                ST_DRIVE: begin
                    if (drive_done) begin
                        state_d = ST_SENSE;
                    end
                end
                ST_SENSE: begin
                    // Own drive sits in the synchroniser; decide only once it flushed
                    if (sense_done && !soft_sync) begin
                        state_d = ST_DRIVE;
                    end else if (sense_done) begin
                        state_d = ST_RUN;
                    end
                end
                default: begin
                    state_d = ST_POR;
                end
            endcase
        end
    end

    // Power-on sequence counter; restarts whenever the hard pin is low
    always @* begin
        por_cnt_d = por_cnt_q;
        if (!hard_sync) begin
            por_cnt_d = {`POR_CNT_W{1'b0}};
        end else if (state_q == ST_POR && !por_done) begin
            por_cnt_d = por_cnt_q + 1'b1;
        end
    end

    // Drive length counter; idles at zero outside the drive phase
    always @* begin
        drive_cnt_d = {`SOFT_CNT_W{1'b0}};
        if (state_q == ST_DRIVE && !drive_done) begin
            drive_cnt_d = drive_cnt_q + 1'b1;
        end
    end

    // Sense window counter; idles at zero outside the sense phase
    always @* begin
        sense_cnt_d = {`SENSE_CNT_W{1'b0}};
        if (state_q == ST_SENSE && !sense_done) begin
            sense_cnt_d = sense_cnt_q + 1'b1;
        end
    end

    // State register
    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= ST_POR;
        end else begin
            state_q <= state_d;
        end
    end

    // Power-on counter register
    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            por_cnt_q <= {`POR_CNT_W{1'b0}};
        end else begin
            por_cnt_q <= por_cnt_d;
        end
    end

    // Drive counter register
    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            drive_cnt_q <= {`SOFT_CNT_W{1'b0}};
        end else begin
            drive_cnt_q <= drive_cnt_d;
        end
    end

    // Sense counter register
    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sense_cnt_q <= {`SENSE_CNT_W{1'b0}};
        end else begin
            sense_cnt_q <= sense_cnt_d;
        end
    end

    // Output decode; por spares only clock logic, core reset also spares debug
    always @* begin
        por_reset_d  = 1'b1;
        core_reset_d = 1'b1;
        cpu_run_d    = 1'b0;
        case (state_d)
            ST_POR: begin
                por_reset_d  = 1'b1;
                core_reset_d = 1'b1;
                cpu_run_d    = 1'b0;
            end
            ST_RUN: begin
                por_reset_d  = 1'b0;
                core_reset_d = 1'b0;
                cpu_run_d    = 1'b1;
            end
            ST_DRIVE, ST_SENSE: begin
                por_reset_d  = 1'b0;
                core_reset_d = 1'b1;
                cpu_run_d    = 1'b0;
            end
            default: begin
                por_reset_d  = 1'b1;
                core_reset_d = 1'b1;
                cpu_run_d    = 1'b0;
            end
        endcase
    end

    // Registered outputs, so no decode glitch reaches the reset nets
    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            por_reset_out  <= 1'b1;
            core_reset_out <= 1'b1;
            cpu_run_out    <= 1'b0;
        end else begin
            por_reset_out  <= por_reset_d;
            core_reset_out <= core_reset_d;
            cpu_run_out    <= cpu_run_d;
        end
    end
endmodule // external_reset_pin_control
`default_nettype wire

/* reset_pin_regs.vh */
`ifndef RESET_PIN_REGS_VH
`define RESET_PIN_REGS_VH

// Low drive on the soft reset pin, in system clock cycles
`define SOFT_DRIVE_CYCLES   6
`define SOFT_CNT_W          3
// Power-on style sequence length, in system clock cycles
`define POR_SEQ_CYCLES      16
`define POR_CNT_W           5
// Sense window after each drive, in system clock cycles
`define SENSE_CYCLES        4
`define SENSE_CNT_W         2
// Sequencer states
`define ST_POR              2'h0
`define ST_RUN              2'h1
`define ST_DRIVE            2'h2
`define ST_SENSE            2'h3

`endif

/* pin_sync.v */
`timescale 1ns/1ps
`default_nettype none
// Two flop synchroniser; first stage is read only by the second
module pin_sync #(
    parameter RESET_VAL = 1'b1
) (
    input  wire sys_clk_in,
    input  wire reset_in,
    input  wire pin_in,
    output wire pin_out
);
    reg meta_q;
    reg sync_q;

    // Presets to RESET_VAL: released (high) for the soft pin, in reset (low) for the hard pin
    always @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_out = sync_q;
endmodule // pin_sync
`default_nettype wire

/* reset_pin_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_pin_chk (
    input wire logic sys_clk_in, reset_in, hard_reset_in_n, soft_reset_in_n, soft_reset_out,
    input wire logic soft_reset_oe_out, por_reset_out, core_reset_out, cpu_run_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    a_hard_holds: assert property (!hard_reset_in_n [*4] |=> por_reset_out)
        else $error("por");
    a_por_stops: assert property (por_reset_out |-> core_reset_out && !cpu_run_out)
        else $error("por run");
    a_low_drives: assert property (hard_reset_in_n && cpu_run_out && !soft_reset_in_n
        |-> ##[1:4] soft_reset_oe_out) else $error("no drive");
    a_run_clean: assert property (cpu_run_out |-> !core_reset_out)
        else $error("run");
    a_drive_low: assert property (soft_reset_oe_out |-> !soft_reset_out && core_reset_out)
        else $error("drive");
    a_drive_six: assert property ($rose(soft_reset_oe_out) |-> soft_reset_oe_out [*6]
        ##1 !soft_reset_oe_out) else $error("width");
    a_high_ends: assert property ((soft_reset_in_n && !por_reset_out) [*8]
        |-> !core_reset_out) else $error("stuck");
    a_sense_gap: assert property ($fell(soft_reset_oe_out) |-> !soft_reset_oe_out [*4])
        else $error("gap");
    c_drive: cover property ($rose(soft_reset_oe_out));
    c_redrive: cover property ($fell(soft_reset_oe_out) ##[1:8] soft_reset_oe_out);
    c_run: cover property ($rose(cpu_run_out));
endmodule // reset_pin_chk
bind external_reset_pin_control reset_pin_chk i_reset_pin_chk (.sys_clk_in, .reset_in,
    .hard_reset_in_n, .soft_reset_in_n, .soft_reset_out, .soft_reset_oe_out, .por_reset_out,
    .core_reset_out, .cpu_run_out);
`default_nettype wire

/* board_reset_src.sv */
`timescale 1ns/1ps
`default_nettype none
module board_reset_src (
    input  wire logic pull_low_in,
    input  wire logic oe_in,
    input  wire logic drive_in,
    output wire logic pin_n_out
);
    // Pulled-up wire, low whenever either party pulls it
    assign pin_n_out = !(pull_low_in || (oe_in && !drive_in));
endmodule // board_reset_src
`default_nettype wire

/* external_reset_pin_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin checked++; if ((g) !== (x)) begin miscompares++; \
    $display("mismatch %s exp %0d got %0d", n, x, g); end end
module external_reset_pin_control_test;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic hard_reset_in_n = 1'b0;
    logic pull_low = 1'b0;
    logic oe_q = 1'b0;
    logic run_q = 1'b0;
    wire  soft_reset_in_n, soft_reset_out, soft_reset_oe_out, por_reset_out, core_reset_out;
    wire  cpu_run_out;
    int   miscompares = 0, checked = 0, bursts = 0, want, m;
    int   exp_q[$];
    always #2.5 sys_clk_in = ~sys_clk_in;
    board_reset_src i_board_reset_src (.pull_low_in(pull_low), .oe_in(soft_reset_oe_out),
        .drive_in(soft_reset_out), .pin_n_out(soft_reset_in_n));
    external_reset_pin_control i_external_reset_pin_control (.sys_clk_in, .reset_in,
        .hard_reset_in_n, .soft_reset_in_n, .soft_reset_out, .soft_reset_oe_out,
        .por_reset_out, .core_reset_out, .cpu_run_out);
    // Count drive bursts off the launching edge; each run start takes the oldest note
    always @(negedge sys_clk_in) begin
        oe_q <= soft_reset_oe_out;
        run_q <= cpu_run_out;
        if (soft_reset_oe_out && !oe_q) bursts <= bursts + 1;
        if (cpu_run_out && !run_q && exp_q.size() > 0) begin
            want = exp_q.pop_front();
            `CHK("bursts", want, bursts)
            `CHK("core", 0, core_reset_out)
            bursts <= 0;
        end
    end
    task wait_run;
        for (int i = 0; i < 300 && cpu_run_out !== 1'b1; i++) @(negedge sys_clk_in);
        repeat (2) @(negedge sys_clk_in);
        `CHK("run", 1, cpu_run_out)
    endtask
    task hard_pulse;
        hard_reset_in_n = 1'b0;
        repeat (20 + $urandom % 20) @(negedge sys_clk_in);
        `CHK("por", 1, por_reset_out)
        exp_q.push_back(0);
        hard_reset_in_n = 1'b1;
        wait_run();
        `CHK("por_end", 0, por_reset_out)
        $display("hard test done");
    endtask
    task test_done;
        if (exp_q.size() != 0) miscompares++;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
    initial begin
        void'($urandom(32'h8EA11B24));
        repeat (10) @(negedge sys_clk_in);
        reset_in = 1'b0;
        hard_pulse();
        // Board holds the pin low for 10m+5 cycles, clear of sense edges
        for (int t = 0; t < 5; t++) begin
            m = $urandom % 4;
            exp_q.push_back(m + 1);
            pull_low = 1'b1;
            repeat (10 * m + 5) @(negedge sys_clk_in);
            `CHK("core_hold", 1, core_reset_out)
            pull_low = 1'b0;
            `CHK("por_soft", 0, por_reset_out)
            wait_run();
            $display("soft test %0d done", t);
        end
        hard_pulse();
        test_done();
    end
endmodule // external_reset_pin_control_test
`default_nettype wire
